// ### inc/ptc_pkg.sv
// Constants shared by the paired timer control block
//
// Functional notes
// (RULE1) Input divider select 00/01/10/11 gives 1:1, 1:8, 1:64, 1:256 counts.
// (RULE2) Chain select bit 3 set joins lower and upper timers into one 32-bit count.
// (RULE3) Chain select clear runs two separate 16-bit timers, each on its own control.
// (RULE4) In 32-bit mode every upper control bit is ignored; lower control rules all.
// (RULE5) Source select set counts external pin rising edges; clear counts half CLK.
// (RULE6) Writing a control register while its run bit is set clears its prescaler.
// (RULE7) In 32-bit mode lower inputs clock and gate; match flags the upper interrupt.
// (RULE8) In 32-bit mode upper count word holds msw, lower count word holds lsw.
// (RULE9) Gate bit ignored with external source; internal source counts only while gate high.
package ptc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int PS_W = 8;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL_LO = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_UP = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_COUNT_UP = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_UP = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h7;

  // ****************************************************
  // Control field positions and masks
  // ****************************************************
  localparam int RUN_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int DIV_HI = 5;
  localparam int DIV_LO = 4;
  localparam int CHAIN_BIT = 3;
  localparam int SRC_BIT = 1;
  localparam logic [DATA_W-1:0] CTRL_LO_MASK = 16'ha07a;
  localparam logic [DATA_W-1:0] CTRL_UP_MASK = 16'ha072;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PERIOD_RESET = 16'hffff;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ****************************************************
  // Interrupt bits and divider codes
  // ****************************************************
  localparam int IRQ_LO_BIT = 0;
  localparam int IRQ_UP_BIT = 1;
  typedef enum logic [1:0] {
    PTC_DIV_1 = 2'b00,
    PTC_DIV_8 = 2'b01,
    PTC_DIV_64 = 2'b10,
    PTC_DIV_256 = 2'b11
  } ptc_div_e;
  localparam logic [PS_W-1:0] PS_LAST_1 = 8'h00;
  localparam logic [PS_W-1:0] PS_LAST_8 = 8'h07;
  localparam logic [PS_W-1:0] PS_LAST_64 = 8'h3f;
  localparam logic [PS_W-1:0] PS_LAST_256 = 8'hff;
endpackage

// ### src/ptc_prescale.sv
// Input prescaler of one timer
module ptc_prescale
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic tick,
  input wire logic [1:0] sel,
  output logic pulse
);
  import ptc_pkg::*;

  logic [PS_W-1:0] cnt;
  logic [PS_W-1:0] next_cnt;
  logic [PS_W-1:0] last;
  logic next_pulse;

  always_comb begin
    case (ptc_div_e'(sel)) // RULE1
      PTC_DIV_1: last = PS_LAST_1;
      PTC_DIV_8: last = PS_LAST_8;
      PTC_DIV_64: last = PS_LAST_64;
      PTC_DIV_256: last = PS_LAST_256;
      default: last = PS_LAST_1;
    endcase
    next_cnt = cnt;
    next_pulse = 1'b0;
    if (clear) begin
      next_cnt = '0; // RULE6
    end else if (tick) begin
      if (cnt >= last) begin
        next_cnt = '0;
        next_pulse = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end
endmodule

// ### src/ptc_top.sv
// Paired 16/32-bit timer pair with register port and interrupt
module ptc_top
  import ptc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [ptc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [ptc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ptc_pkg::DATA_W-1:0] RDATA,
  input wire logic [1:0] EXTERNAL_COUNT_PIN,
  input wire logic [1:0] GATE_PIN,
  input wire logic IDLE,
  output logic IRQ,
  output logic [1:0] MATCH
);
  import ptc_pkg::*;

  // ****************************************************
  // Pin synchronisers and internal half-rate clock
  // ****************************************************
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] gate_s1;
  logic [1:0] gate_s2;
  logic half;
  logic next_half;
  logic [1:0] pin_rise;

  always_comb begin
    next_half = ~half;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
      gate_s1 <= 2'h0;
      gate_s2 <= 2'h0;
      half <= 1'b0;
    end else begin
      pin_s1 <= EXTERNAL_COUNT_PIN;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      gate_s1 <= GATE_PIN;
      gate_s2 <= gate_s1;
      half <= next_half;
    end
  end

  assign pin_rise = pin_s2 & ~pin_s3;

  // ****************************************************
  // Register state
  // ****************************************************
  logic [DATA_W-1:0] ctrl_lo;
  logic [DATA_W-1:0] ctrl_up;
  logic [DATA_W-1:0] period_lo;
  logic [DATA_W-1:0] period_up;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [DATA_W-1:0] next_ctrl_lo;
  logic [DATA_W-1:0] next_ctrl_up;
  logic [DATA_W-1:0] next_period_lo;
  logic [DATA_W-1:0] next_period_up;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [DATA_W-1:0] next_rdata;
  logic next_irq;
  logic [1:0] next_match;

  // ****************************************************
  // Counter state
  // ****************************************************
  logic [DATA_W-1:0] count_lo;
  logic [DATA_W-1:0] count_up;
  logic [DATA_W-1:0] next_count_lo;
  logic [DATA_W-1:0] next_count_up;
  logic [1:0] match_set;

  // ****************************************************
  // Effective settings per timer
  // ****************************************************
  logic chain;
  logic wr_ctrl_lo;
  logic wr_ctrl_up;
  logic [DATA_W-1:0] ctl_eff [2];
  logic [1:0] run_eff;
  logic [1:0] raw_tick;
  logic [1:0] ps_clear;
  logic [1:0] ps_pulse;
  logic [1:0] ctl_run;

  assign chain = ctrl_lo[CHAIN_BIT];
  assign wr_ctrl_lo = WR && (ADDR == OFF_CTRL_LO);
  assign wr_ctrl_up = WR && (ADDR == OFF_CTRL_UP);
  assign ctl_run = {ctrl_up[RUN_BIT], ctrl_lo[RUN_BIT]};
  assign ps_clear[0] = wr_ctrl_lo && ctl_run[0]; // RULE6
  assign ps_clear[1] = wr_ctrl_up && ctl_run[1]; // RULE6

  generate
    for (genvar i = 0; i < 2; i++) begin : g_timer
      logic [DATA_W-1:0] own;
      logic int_tick;
      assign own = (i == 0) ? ctrl_lo : ctrl_up;
      assign ctl_eff[i] = (chain && i == 1) ? ctrl_lo : own; // RULE4
      assign run_eff[i] = ctl_eff[i][RUN_BIT] &&
                          !(IDLE && ctl_eff[i][IDLE_HALT_BIT]);
      assign int_tick = half &&
                        (!ctl_eff[i][GATE_BIT] || gate_s2[i]); // RULE9
      assign raw_tick[i] = run_eff[i] &&
                           (ctl_eff[i][SRC_BIT] ? pin_rise[i] : int_tick); // RULE5

      ptc_prescale u_prescale (
        .clk(CLK),
        .rstn(RSTN),
        .clear(ps_clear[i]),
        .tick(raw_tick[i]),
        .sel(ctl_eff[i][DIV_HI:DIV_LO]),
        .pulse(ps_pulse[i])
      );
    end
  endgenerate

  // ****************************************************
  // Counting and period match
  // ****************************************************
  always_comb begin
    next_count_lo = count_lo;
    next_count_up = count_up;
    match_set = 2'h0;
    if (chain) begin
      if (ps_pulse[0] && run_eff[0]) begin // RULE7
        if ({count_up, count_lo} == {period_up, period_lo}) begin // RULE2
          next_count_lo = COUNT_RESET;
          next_count_up = COUNT_RESET;
          match_set[IRQ_UP_BIT] = 1'b1; // RULE7
        end else begin
          {next_count_up, next_count_lo} = {count_up, count_lo} + 32'h1; // RULE8
        end
      end
    end else begin
      if (ps_pulse[0] && run_eff[0]) begin // RULE3
        if (count_lo == period_lo) begin
          next_count_lo = COUNT_RESET;
          match_set[IRQ_LO_BIT] = 1'b1;
        end else begin
          next_count_lo = count_lo + 16'h1;
        end
      end
      if (ps_pulse[1] && run_eff[1]) begin // RULE3
        if (count_up == period_up) begin
          next_count_up = COUNT_RESET;
          match_set[IRQ_UP_BIT] = 1'b1;
        end else begin
          next_count_up = count_up + 16'h1;
        end
      end
    end
    if (WR && ADDR == OFF_COUNT_LO) begin
      next_count_lo = WDATA;
    end
    if (WR && ADDR == OFF_COUNT_UP) begin
      next_count_up = WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_lo <= COUNT_RESET;
      count_up <= COUNT_RESET;
    end else begin
      count_lo <= next_count_lo;
      count_up <= next_count_up;
    end
  end

  // ****************************************************
  // Register writes, reads and interrupt
  // ****************************************************
  always_comb begin
    next_ctrl_lo = ctrl_lo;
    next_ctrl_up = ctrl_up;
    next_period_lo = period_lo;
    next_period_up = period_up;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (wr_ctrl_lo) begin
      next_ctrl_lo = WDATA & CTRL_LO_MASK;
    end
    if (wr_ctrl_up) begin
      next_ctrl_up = WDATA & CTRL_UP_MASK;
    end
    if (WR && ADDR == OFF_PERIOD_LO) begin
      next_period_lo = WDATA;
    end
    if (WR && ADDR == OFF_PERIOD_UP) begin
      next_period_up = WDATA;
    end
    if (WR && ADDR == OFF_IRQ_MASK) begin
      next_irq_mask = WDATA[1:0];
    end
    if (WR && ADDR == OFF_IRQ_STATUS) begin
      next_irq_status = irq_status & ~WDATA[1:0];
    end
    next_irq_status = next_irq_status | match_set;
    next_irq = |(next_irq_status & next_irq_mask);
    next_match = match_set;
    next_rdata = '0;
    if (RD) begin
      case (ADDR)
        OFF_CTRL_LO: next_rdata = ctrl_lo;
        OFF_CTRL_UP: next_rdata = ctrl_up;
        OFF_COUNT_LO: next_rdata = count_lo; // RULE8
        OFF_COUNT_UP: next_rdata = count_up; // RULE8
        OFF_PERIOD_LO: next_rdata = period_lo;
        OFF_PERIOD_UP: next_rdata = period_up;
        OFF_IRQ_STATUS: next_rdata = {14'h0, irq_status};
        OFF_IRQ_MASK: next_rdata = {14'h0, irq_mask};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_lo <= CTRL_RESET;
      ctrl_up <= CTRL_RESET;
      period_lo <= PERIOD_RESET;
      period_up <= PERIOD_RESET;
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      RDATA <= '0;
      IRQ <= 1'b0;
      MATCH <= 2'h0;
    end else begin
      ctrl_lo <= next_ctrl_lo;
      ctrl_up <= next_ctrl_up;
      period_lo <= next_period_lo;
      period_up <= next_period_up;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      RDATA <= next_rdata;
      IRQ <= next_irq;
      MATCH <= next_match;
    end
  end
endmodule

// ### tb/ptc_top_chk.sv
// Port checker for the paired timer control block
module ptc_top_chk
  import ptc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [ptc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [ptc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [ptc_pkg::DATA_W-1:0] RDATA,
  input wire logic [1:0] EXTERNAL_COUNT_PIN,
  input wire logic [1:0] GATE_PIN,
  input wire logic IDLE,
  input wire logic IRQ,
  input wire logic [1:0] MATCH
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Chain mode tracking and assertions
  // ****************************************
  logic chain;
  logic next_chain;
  always_comb begin
    next_chain = chain;
    if (WR && ADDR == OFF_CTRL_LO) begin
      next_chain = WDATA[CHAIN_BIT];
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      chain <= 1'b0;
    end else begin
      chain <= next_chain;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_LO_READBACK: assert property (
    WR && ADDR == OFF_CTRL_LO ##1 RD && ADDR == OFF_CTRL_LO
    |=> RDATA == ($past(WDATA, 2) & CTRL_LO_MASK)) else $error("Lower control readback");
  AST_UP_READBACK: assert property (
    WR && ADDR == OFF_CTRL_UP ##1 RD && ADDR == OFF_CTRL_UP
    |=> RDATA == ($past(WDATA, 2) & CTRL_UP_MASK)) else $error("Upper control readback");
  AST_UNMAPPED: assert property (
    RD && ADDR[3] |=> RDATA == '0) else $error("Unmapped read not zero");
  AST_RDATA_IDLE: assert property (
    !RD |=> RDATA == '0) else $error("Read data outside read cycle");
  AST_MATCH_PULSE: assert property (
    MATCH[1] |=> !MATCH[1]) else $error("Upper match longer than one cycle");
  AST_CHAIN_NO_LO: assert property (
    chain |=> !MATCH[0]) else $error("Lower match in chained mode");
  AST_MASK_OFF: assert property (
    WR && ADDR == OFF_IRQ_MASK && WDATA[1:0] == 2'h0 |-> ##2 !IRQ)
    else $error("Interrupt despite zero mask");
  AST_W1C: assert property (
    WR && ADDR == OFF_IRQ_STATUS && WDATA[1:0] == 2'h3 ##1 (MATCH == 2'h0) [*2] |-> !IRQ)
    else $error("Interrupt after status clear");
  C_UP_MATCH: cover property (chain && MATCH[1]);
  C_LO_MATCH: cover property (MATCH[0]);
  C_IRQ: cover property ($rose(IRQ));
endmodule

bind ptc_top ptc_top_chk chk (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .EXTERNAL_COUNT_PIN, .GATE_PIN, .IDLE, .IRQ, .MATCH);

// ### tb/ptc_top_test.sv
// Register level testbench for the paired timer control block
module ptc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ptc_pkg::*;
  // ****************************************
  // Signals and register port tasks
  // ****************************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic idle_s = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [1:0] ext_pin = '0;
  logic [1:0] gate_pin = '0;
  logic [DATA_W-1:0] rdata;
  logic irq;
  logic [1:0] match;
  logic [15:0] v, a, b;
  int mismatches = 0;
  int tests_run = 0;
  int n_of[4] = '{1, 8, 64, 256};
  always #25 clk = ~clk;
  ptc_top dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .EXTERNAL_COUNT_PIN(ext_pin), .GATE_PIN(gate_pin), .IDLE(idle_s),
    .IRQ(irq), .MATCH(match));
  task automatic end_of_test;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    wr_s <= 1'b1;
    rd_s <= 1'b0;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] q);
    rd_s <= 1'b1;
    wr_s <= 1'b0;
    addr <= ad;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    q = rdata;
  endtask
  task automatic idle(input int n);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic delta(input logic [15:0] ctrl, input int gap, input logic [15:0] exp);
    wr(OFF_COUNT_LO, 16'h0000);
    wr(OFF_CTRL_LO, ctrl);
    idle(20);
    rd(OFF_COUNT_LO, a);
    idle(gap - 2);
    rd(OFF_COUNT_LO, b);
    wr(OFF_CTRL_LO, 16'h0000);
    chk(b - a, exp);
  endtask
  task automatic wait_irq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 300) begin
      idle(1);
      i++;
    end
    chk({15'h0000, irq}, 16'h0001);
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_CTRL_LO, v);
    chk(v, CTRL_RESET);
    rd(OFF_PERIOD_LO, v);
    chk(v, PERIOD_RESET);
    rd(4'hf, v);
    chk(v, 16'h0000);
    wr(OFF_CTRL_LO, 16'h7fff);
    rd(OFF_CTRL_LO, v);
    chk(v, 16'h207a);
    wr(OFF_CTRL_UP, 16'h7fff);
    rd(OFF_CTRL_UP, v);
    chk(v, 16'h2072);
    wr(OFF_CTRL_UP, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      delta(16'h8000 | 16'(c << 4), 2048, 16'(2048 / (2 * n_of[c])));
    end
    delta(16'h8040, 200, 16'h0000);
    gate_pin[0] <= 1'b1;
    delta(16'h8040, 200, 16'd100);
    gate_pin[0] <= 1'b0;
    idle_s <= 1'b1;
    delta(16'ha000, 200, 16'h0000);
    idle_s <= 1'b0;
    wr(OFF_CTRL_LO, 16'h8030);
    idle(5);
    rd(OFF_COUNT_LO, a);
    repeat (8) begin
      idle(200);
      wr(OFF_CTRL_LO, 16'h8030);
    end
    rd(OFF_COUNT_LO, b);
    chk(b - a, 16'h0000);
    wr(OFF_CTRL_LO, 16'h8042);
    idle(10);
    rd(OFF_COUNT_LO, a);
    repeat (10) begin
      ext_pin[0] <= 1'b1;
      idle(4);
      ext_pin[0] <= 1'b0;
      idle(4);
    end
    idle(10);
    rd(OFF_COUNT_LO, b);
    chk(b - a, 16'd10);
    wr(OFF_CTRL_LO, 16'h0000);
    wr(OFF_COUNT_LO, 16'hfff0);
    wr(OFF_COUNT_UP, 16'h0000);
    wr(OFF_CTRL_LO, 16'h8000);
    idle(100);
    rd(OFF_COUNT_UP, v);
    chk(v, 16'h0000);
    wr(OFF_CTRL_UP, 16'h8010);
    idle(20);
    rd(OFF_COUNT_UP, a);
    idle(254);
    rd(OFF_COUNT_UP, b);
    wr(OFF_CTRL_UP, 16'h0000);
    chk(b - a, 16'd16);
    wr(OFF_CTRL_LO, 16'h0000);
    wr(OFF_COUNT_LO, 16'hfff0);
    wr(OFF_COUNT_UP, 16'h0000);
    wr(OFF_CTRL_UP, 16'h0030);
    wr(OFF_CTRL_LO, 16'h8008);
    idle(100);
    rd(OFF_COUNT_UP, v);
    chk(v, 16'h0001);
    wr(OFF_CTRL_LO, 16'h0000);
    wr(OFF_IRQ_STATUS, 16'h0003);
    wr(OFF_COUNT_LO, 16'h0000);
    wr(OFF_COUNT_UP, 16'h0000);
    wr(OFF_PERIOD_LO, 16'h0010);
    wr(OFF_PERIOD_UP, 16'h0000);
    wr(OFF_IRQ_MASK, 16'h0002);
    wr(OFF_CTRL_LO, 16'h8008);
    wait_irq;
    wr(OFF_CTRL_LO, 16'h0000);
    rd(OFF_IRQ_STATUS, v);
    chk(v, 16'h0002);
    wr(OFF_IRQ_MASK, 16'h0000);
    idle(3);
    chk({15'h0000, irq}, 16'h0000);
    wr(OFF_IRQ_MASK, 16'h0003);
    idle(3);
    chk({15'h0000, irq}, 16'h0001);
    wr(OFF_IRQ_STATUS, 16'h0003);
    idle(3);
    chk({15'h0000, irq}, 16'h0000);
    wr(OFF_COUNT_LO, 16'h0000);
    wr(OFF_CTRL_LO, 16'h8000);
    wait_irq;
    wr(OFF_CTRL_LO, 16'h0000);
    rd(OFF_IRQ_STATUS, v);
    chk(v, 16'h0001);
    end_of_test;
  end
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule
